// *** core/asbrp_core.sv ***
// converter control: trigger edges, power state, busy, latched result and read port
// assumes synchronous inputs; conversion result arrives from the analog side as sar_code
`default_nettype none

module asbrp_core
  import asbrp_pkg::*;
#(
  parameter int unsigned CONV_LEN = CONV_CYC,
  parameter int unsigned WAKE_LEN = POWER_UP_CYC
) (
  input  wire logic                core_clk,
  input  wire logic                reset,
  input  wire logic                sample_trigger_n,
  input  wire asbrp_rd_t           rd,
  input  wire logic [RESULT_W-1:0] sar_code,
  output logic                     busy,
  output logic                     powered,
  output logic [RESULT_W-1:0]      result_bus_o,
  output logic [RESULT_W-1:0]      result_bus_oe
);

  logic             trig_d_r;
  logic             trig_rise;
  logic             trig_fall;
  logic             start_pulse;
  logic             conv_go;
  logic             conv_done;
  logic [CNT_W-1:0] cnt_r;
  asbrp_state_t     state_r;
  logic [RESULT_W-1:0] result_r;
  asbrp_bus_t       bus;

  // last cycle at which busy may still be seen low again after a start
  localparam int CONV_END = CONV_LEN + 1;

  // idle-high so a trigger held high at reset release is not seen as a rising edge
  always_ff @(posedge core_clk) begin
    if (reset) begin
      trig_d_r <= 1'b1;
    end else begin
      trig_d_r <= sample_trigger_n;
    end
  end

  assign trig_rise = sample_trigger_n & ~trig_d_r;
  assign trig_fall = ~sample_trigger_n & trig_d_r;

  asbrp_pulse #(
    .LEN (START_PULSE_CYC)
  ) u_start_pulse (
    .core_clk (core_clk),
    .reset    (reset),
    .fire     (trig_rise),
    .active   (start_pulse)
  );

  // a fall during the internal pulse is ignored, not deferred
  assign conv_go   = trig_fall & ~start_pulse & (state_r == ASBRP_IDLE);
  assign conv_done = (state_r == ASBRP_CONV) && (cnt_r == CNT_W'(1));

  always_ff @(posedge core_clk) begin
    if (reset) begin
      state_r <= ASBRP_OFF;
      cnt_r   <= '0;
    end else begin
      case (state_r)
        ASBRP_OFF: begin
          if (trig_rise) begin
            state_r <= ASBRP_WAKE;
            cnt_r   <= CNT_W'(WAKE_LEN);
          end
        end
        ASBRP_WAKE: begin
          // leave one count early so powered shows within the wake time of the pin edge
          if (cnt_r <= CNT_W'(2)) begin
            state_r <= ASBRP_IDLE;
            cnt_r   <= '0;
          end else begin
            cnt_r <= cnt_r - 1'b1;
          end
        end
        ASBRP_IDLE: begin
          if (conv_go) begin
            state_r <= ASBRP_CONV;
            cnt_r   <= CNT_W'(CONV_LEN);
          end
        end
        ASBRP_CONV: begin
          if (conv_done) begin
            cnt_r <= '0;
            // trigger level at the end picks power-down or high-speed mode
            if (sample_trigger_n) begin
              state_r <= ASBRP_IDLE;
            end else begin
              state_r <= ASBRP_OFF;
            end
          end else begin
            cnt_r <= cnt_r - 1'b1;
          end
        end
        default: begin
          state_r <= ASBRP_OFF;
          cnt_r   <= '0;
        end
      endcase
    end
  end

  // busy is combinational on the state so it rises in the cycle after the fall
  assign busy    = (state_r == ASBRP_CONV);
  assign powered = (state_r == ASBRP_IDLE) || (state_r == ASBRP_CONV);

  always_ff @(posedge core_clk) begin
    if (reset) begin
      result_r <= RESULT_RST;
    end else if (conv_done) begin
      result_r <= sar_code;
    end
  end

  // bus enable follows the strobes directly: no clock latency on access or release
  always_comb begin
    bus.data = result_r;
    bus.oe   = ~rd.chip_sel_n & ~rd.read_n;
  end

  assign result_bus_o  = bus.data;
  assign result_bus_oe = {RESULT_W{bus.oe}};

  busy_rise_a: assert property (@(posedge core_clk) disable iff (reset)
    conv_go |=> busy) else $error("busy late after trigger fall");

  busy_len_a: assert property (@(posedge core_clk) disable iff (reset)
    $rose(busy) |-> busy [*8]) else $error("busy dropped early");

  conv_bound_a: assert property (@(posedge core_clk) disable iff (reset)
    conv_go |-> ##[1:CONV_END] !busy) else $error("conversion overran");

  pulse_block_a: assert property (@(posedge core_clk) disable iff (reset)
    (trig_fall && start_pulse) |=> !busy || $past(busy)) else $error("start during pulse");

  pulse_len_a: assert property (@(posedge core_clk) disable iff (reset)
    trig_rise |=> start_pulse [*8]) else $error("start pulse too short");

  wake_time_a: assert property (@(posedge core_clk) disable iff (reset)
    (state_r == ASBRP_OFF && trig_rise) |-> ##20 powered) else $error("power-up late");

  bus_drive_a: assert property (@(posedge core_clk) disable iff (reset)
    bus.oe == (!rd.chip_sel_n && !rd.read_n)) else $error("bus enable wrong");

  pd_mode_a: assert property (@(posedge core_clk) disable iff (reset)
    (conv_done && !sample_trigger_n) |=> !powered) else $error("no power-down");

  stay_on_a: assert property (@(posedge core_clk) disable iff (reset)
    (conv_done && sample_trigger_n) |=> powered) else $error("powered down wrongly");

  hold_result_a: assert property (@(posedge core_clk) disable iff (reset)
    !conv_done |=> result_r == $past(result_r)) else $error("result changed");

endmodule : asbrp_core

`default_nettype wire

// *** core/asbrp_pkg.sv ***
// constants and carrier types for the sample-trigger / busy / result-read port
// assumes a single 20 MHz core clock and synchronous, active-high reset
//
// Behaviour
// - rising trigger edge launches an internal start pulse lasting 1 us
// - falling trigger edge starts conversion only while internal start pulse is low
// - device fully powered within 1 us of rising edge; host waits that long
// - a started conversion completes with result available within 4.5 us
// - busy rises no later than 30 ns after trigger falling edge; code raises it at the next 50 ns clock edge instead
// - busy stays high through the conversion and drops when it ends
// - result bus undriven except while chip select and read strobe are both low
// - valid result on bus within 10 ns of read strobe low with select low
// - bus released within 10 ns of read strobe returning high
// - trigger level sampled at conversion end chooses power-down or stay powered
// - eight three-state result outputs carry result bits 0 to 7
// - after supply comes up the device sits powered down until a rising edge
`default_nettype none

package asbrp_pkg;

  localparam int unsigned CLK_PERIOD_NS     = 50;
  localparam int unsigned START_PULSE_NS    = 1000;
  localparam int unsigned POWER_UP_NS       = 1000;
  localparam int unsigned CONV_TIME_NS      = 4500;
  localparam int unsigned BUSY_DELAY_NS     = 30;
  // least times round up, longest times round down, never under one cycle
  localparam int unsigned START_PULSE_CYC   = (START_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned POWER_UP_CYC      = (POWER_UP_NS / CLK_PERIOD_NS) > 0 ? POWER_UP_NS / CLK_PERIOD_NS : 1;
  localparam int unsigned CONV_CYC          = (CONV_TIME_NS / CLK_PERIOD_NS) > 0 ? CONV_TIME_NS / CLK_PERIOD_NS : 1;
  localparam int unsigned BUSY_DELAY_CYC    = (BUSY_DELAY_NS / CLK_PERIOD_NS) > 0 ? BUSY_DELAY_NS / CLK_PERIOD_NS : 1;

  localparam int unsigned CNT_W             = 8;
  localparam int unsigned RESULT_W          = 8;
  localparam logic [RESULT_W-1:0] RESULT_RST = 8'h00;

  typedef enum logic [3:0] {
    ASBRP_OFF  = 4'h1,
    ASBRP_WAKE = 4'h2,
    ASBRP_IDLE = 4'h4,
    ASBRP_CONV = 4'h8
  } asbrp_state_t;

  // host-side read strobes
  typedef struct packed {
    logic chip_sel_n;
    logic read_n;
  } asbrp_rd_t;

  // three-state result bus as output value plus enable
  typedef struct packed {
    logic [RESULT_W-1:0] data;
    logic                oe;
  } asbrp_bus_t;

endpackage : asbrp_pkg

`default_nettype wire

// *** core/asbrp_pulse.sv ***
// one-shot: fixed-length pulse from a one-cycle trigger, retriggerable
// assumes core clock domain, synchronous active-high reset
`default_nettype none

module asbrp_pulse
  import asbrp_pkg::*;
#(
  parameter int unsigned LEN = START_PULSE_CYC
) (
  input  wire logic core_clk,
  input  wire logic reset,
  input  wire logic fire,
  output logic      active
);

  logic [CNT_W-1:0] cnt_r;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      cnt_r <= '0;
    end else if (fire) begin
      cnt_r <= CNT_W'(LEN);
    end else if (cnt_r != '0) begin
      cnt_r <= cnt_r - 1'b1;
    end
  end

  assign active = (cnt_r != '0);

endmodule : asbrp_pulse

`default_nettype wire

// *** tb/adc_start_busy_read_port_tb.sv ***
// self-checking bench for the start / busy / result-read control block
// assumes core_clk at 50 ns and a short conversion count for run time
`default_nettype none

module adc_start_busy_read_port_tb
  import asbrp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  localparam int CL = 10;
  logic                core_clk = 1'b0;
  logic                reset    = 1'b1;
  logic                trig_n;
  asbrp_rd_t           rd       = 2'h3;
  logic [RESULT_W-1:0] sar_code = 8'h00;
  logic                busy;
  logic                powered;
  logic [RESULT_W-1:0] bus_o;
  logic [RESULT_W-1:0] bus_oe;
  int                  err_count   = 0;
  int                  comparisons = 0;
  // chip_sel_n, read_n, expected enable
  logic [2:0]          rows[4] = '{3'h6, 3'h2, 3'h4, 3'h1};

`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin err_count++; \
  $display("Error %s expected %h seen %h", nm, ex, got); end end

  always #25 core_clk = ~core_clk;

  asbrp_core #(.CONV_LEN(CL), .WAKE_LEN(4)) DUT (
    .core_clk(core_clk), .reset(reset), .sample_trigger_n(trig_n), .rd(rd),
    .sar_code(sar_code), .busy(busy), .powered(powered),
    .result_bus_o(bus_o), .result_bus_oe(bus_oe)
  );

  asbrp_host host (.core_clk(core_clk), .trig_n(trig_n));

  task automatic results();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : results

  task automatic conv(input logic [7:0] code, input logic end_lvl);
    int w;
    int n;
    w = 0;
    n = 0;
    sar_code = code;
    host.drive(1'b1, 21);
    host.drive(1'b0, 0);
    while (busy !== 1'b1 && w < 3) begin
      @(posedge core_clk);
      #5;
      w++;
    end
    `CHK("busy_rise", 1'b1, busy)
    host.drive(end_lvl, 0);
    while (busy === 1'b1 && n < 200) begin
      n++;
      @(posedge core_clk);
      #5;
    end
    `CHK("busy_len", CL, n)
    `CHK("powered", end_lvl, powered)
    // latch must survive repeated reads and a stale analog code
    sar_code = ~code;
    for (int i = 0; i < 4; i++) begin
      rd = asbrp_rd_t'(rows[i][2:1]);
      #1;
      `CHK("bus_oe", {8{rows[i][0]}}, bus_oe)
      if (rows[i][0])
        `CHK("bus_data", code, bus_o)
      rd = 2'h3;
      #1;
      `CHK("bus_release", 8'h00, bus_oe)
    end
    $display("conversion %h done", code);
  endtask : conv

  initial begin
    #100000;
    err_count++;
    results();
  end

  initial begin
    repeat (2) @(posedge core_clk);
    #5;
    reset = 1'b0;
    `CHK("rst_busy", 1'b0, busy)
    `CHK("rst_powered", 1'b0, powered)
    host.drive(1'b0, 3);
    `CHK("fall_while_off", 1'b0, busy)
    host.drive(1'b1, 6);
    // fall inside the internal start pulse is dropped
    host.drive(1'b0, 3);
    `CHK("fall_in_pulse", 1'b0, busy)
    host.drive(1'b1, 21);
    `CHK("wake", 1'b1, powered)
    $display("wake test done");
    conv(8'ha5, 1'b1);
    conv(8'h3c, 1'b0);
    results();
  end

`undef CHK

endmodule : adc_start_busy_read_port_tb

`default_nettype wire

// *** tb/asbrp_host.sv ***
// host model: drives the start input with the spacing the host owes
// assumes callers enter its task just after a rising clock edge
`default_nettype none

module asbrp_host (
  input  wire logic core_clk,
  output var logic  trig_n
);
  timeunit 1ns;
  timeprecision 1ns;

  initial trig_n = 1'b1;

  // set the level, then let cyc edges pass; callers pick cyc for wake and acquisition
  task automatic drive(input logic v, input int cyc);
    trig_n = v;
    repeat (cyc) begin
      @(posedge core_clk);
      #5;
    end
  endtask : drive

endmodule : asbrp_host

`default_nettype wire
